// ### src/repeat_select_map.svh
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef CONV_CONTROL_MAP_SVH
`define CONV_CONTROL_MAP_SVH
`define OPT_LO_ADDR    8'h3a
`define OPT_HI_ADDR    8'h3b
`define OPT_RESET      16'h2000
`define OPT_REPEAT_BIT 15
`define OPT_START_BIT  14
`define OPT_RANGE_BIT  13
`define CH_SYS_POWER   3'h5
`define CH_CMP_INPUT   3'h7
`define REF_CLK_KHZ    40000
`define BUDGET_MS      25
`define PERIOD_MS      1000
`define TMR_W          26
`endif

// ### src/repeat_select_pkg.sv
// types shared by the converter control modules
package conv_ctrl_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_WAIT} conv_state_t;
   typedef logic [2:0] channel_t;
endpackage

// ### src/interval_timer.sv
// loadable down counter that pulses when a programmed interval has run out
`timescale 1ns/1ps
`include "repeat_select_map.svh"
module interval_timer (
   input  wire logic               ref_clk,
   input  wire logic               rst_n,
   input  wire logic               load,
   input  wire logic [`TMR_W-1:0] period,
   output logic                    expired
);
   logic [`TMR_W-1:0] cnt_q;
   logic              run_q;

   // expires on the last cycle of the interval; a load in that cycle restarts it
   assign expired = run_q && (cnt_q == `TMR_W'(1));

   // ***********************************
   // counter
   // ***********************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         run_q <= 1'b0;
      end else if (load) begin
         cnt_q <= period;
         run_q <= 1'b1;
      end else if (run_q) begin
         cnt_q <= cnt_q - `TMR_W'(1);
         run_q <= !expired;
      end
   end
endmodule

// ### src/channel_pick.sv
// finds the lowest enabled channel at or above a starting index
`timescale 1ns/1ps
module channel_pick
   import conv_ctrl_pkg::*;
(
   input  wire logic [7:0] en,
   input  wire logic [3:0] from_idx,
   output logic            found,
   output channel_t        idx
);
   // descending scan so the lowest qualifying channel is the last one kept
   always_comb begin
      found = 1'b0;
      idx   = '0;
      for (int i = 7; i >= 0; i--) begin
         if (en[i] && (i >= int'(from_idx))) begin
            found = 1'b1;
            idx   = 3'(i);
         end
      end
   end
endmodule

// ### src/adc_conversion_control.sv
// option register and channel sequencer of the monitoring converter
`timescale 1ns/1ps
`include "repeat_select_map.svh"
module adc_conversion_control
   import conv_ctrl_pkg::*;
#(
   parameter int unsigned BUDGET_CYC = `BUDGET_MS * `REF_CLK_KHZ,
   parameter int unsigned PERIOD_CYC = `PERIOD_MS * `REF_CLK_KHZ
) (
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   input  wire logic       low_power_mode,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic     [7:0] reg_rdata,
   output logic            conv_active,
   output logic            conv_start,
   output channel_t        conv_channel,
   output logic            conv_range_hi,
   output logic            result_update,
   output channel_t        result_channel,
   output logic            pass_done
);
   // ***********************************
   // reset release
   // ***********************************
   logic rst_meta_q;
   logic rst_n;

   // assertion is immediate, release is synchronous to avoid recovery hazards
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   // ***********************************
   // option register
   // ***********************************
   logic [15:0] opt_q;
   logic [15:0] opt_d;
   logic        lo_wr;
   logic        hi_wr;
   logic        hw_clr;
   logic        start_q;
   logic        repeat_q;
   logic        range_q;
   logic [7:0]  en_q;
   logic        start_d;

   assign lo_wr    = reg_wr && (reg_addr == `OPT_LO_ADDR);
   assign hi_wr    = reg_wr && (reg_addr == `OPT_HI_ADDR);
   assign start_q  = opt_q[`OPT_START_BIT];
   assign repeat_q = opt_q[`OPT_REPEAT_BIT];
   assign range_q  = opt_q[`OPT_RANGE_BIT];
   assign en_q     = opt_q[7:0];

   // a host write of the start bit beats the hardware clear in the same cycle
   assign start_d = hi_wr  ? reg_wdata[`OPT_START_BIT-8] :
                    hw_clr ? 1'b0 : start_q;

   // every bit is read-write, reserved bits included
   assign opt_d[7:0]  = lo_wr ? reg_wdata : opt_q[7:0];
   assign opt_d[15]   = hi_wr ? reg_wdata[7] : opt_q[15];
   assign opt_d[14]   = start_d;
   assign opt_d[13:8] = hi_wr ? reg_wdata[5:0] : opt_q[13:8];

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         opt_q <= `OPT_RESET;
      end else begin
         opt_q <= opt_d;
      end
   end

   // read data registered; unmapped offsets read as zero
   logic [7:0] rdata_d;
   assign rdata_d = (reg_addr == `OPT_LO_ADDR) ? opt_q[7:0] :
                    (reg_addr == `OPT_HI_ADDR) ? opt_q[15:8] : 8'h00;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_d;
      end
   end

   // ***********************************
   // channel search and timers
   // ***********************************
   conv_state_t state_q;
   conv_state_t state_d;
   logic [7:0]  en_pass_q;
   logic        first_found;
   channel_t    first_idx;
   logic        nx_found;
   channel_t    nx_idx;
   logic [3:0]  nx_from;
   logic        slot_load;
   logic        per_load;
   logic        slot_exp;
   logic        per_exp;
   logic        first;
   logic        upd;
   logic        done;
   channel_t    ch_d;

   // channels advance from the one now converting; snapshot keeps a pass stable
   assign nx_from = {1'b0, conv_channel} + 4'h1;

   channel_pick u_first_pick (
      .en       (en_q),
      .from_idx (4'h0),
      .found    (first_found),
      .idx      (first_idx)
   );

   channel_pick u_next_pick (
      .en       (en_pass_q),
      .from_idx (nx_from),
      .found    (nx_found),
      .idx      (nx_idx)
   );

   interval_timer u_slot_tmr (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .load    (slot_load),
      .period  (`TMR_W'(BUDGET_CYC)),
      .expired (slot_exp)
   );

   interval_timer u_period_tmr (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .load    (per_load),
      .period  (`TMR_W'(PERIOD_CYC)),
      .expired (per_exp)
   );

   // ***********************************
   // sequencer
   // ***********************************
   // low power or a cleared start bit aborts at once; results of an aborted slot are dropped
   always_comb begin
      state_d   = state_q;
      slot_load = 1'b0;
      per_load  = 1'b0;
      first     = 1'b0;
      upd       = 1'b0;
      done      = 1'b0;
      hw_clr    = 1'b0;
      ch_d      = conv_channel;
      case (state_q)
         ST_IDLE: begin
            if (start_q && !low_power_mode) begin
               if (first_found) begin
                  state_d   = ST_CONVERT;
                  slot_load = 1'b1;
                  per_load  = 1'b1;
                  first     = 1'b1;
                  ch_d      = first_idx;
               end else if (!repeat_q) begin
                  hw_clr = 1'b1;
               end
            end
         end
         ST_CONVERT: begin
            if (!start_q || low_power_mode) begin
               state_d = ST_IDLE;
            end else if (slot_exp) begin
               upd = 1'b1;
               if (nx_found) begin
                  slot_load = 1'b1;
                  ch_d      = nx_idx;
               end else begin
                  done = 1'b1;
                  if (repeat_q) begin
                     state_d = ST_WAIT;
                  end else begin
                     hw_clr  = 1'b1;
                     state_d = ST_IDLE;
                  end
               end
            end
         end
         ST_WAIT: begin
            if (!start_q || low_power_mode) begin
               state_d = ST_IDLE;
            end else if (per_exp) begin
               per_load = 1'b1;
               if (first_found) begin
                  state_d   = ST_CONVERT;
                  slot_load = 1'b1;
                  first     = 1'b1;
                  ch_d      = first_idx;
               end
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // scaled range only on the two voltage-input channels
   logic range_hi_d;
   assign range_hi_d = range_q && ((ch_d == `CH_SYS_POWER) || (ch_d == `CH_CMP_INPUT));

   // state and the registered converter outputs
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q        <= ST_IDLE;
         en_pass_q      <= 8'h00;
         conv_active    <= 1'b0;
         conv_start     <= 1'b0;
         conv_channel   <= '0;
         conv_range_hi  <= 1'b0;
         result_update  <= 1'b0;
         result_channel <= '0;
         pass_done      <= 1'b0;
      end else begin
         state_q        <= state_d;
         en_pass_q      <= first ? en_q : en_pass_q;
         conv_active    <= (state_d == ST_CONVERT);
         conv_start     <= slot_load;
         conv_channel   <= ch_d;
         conv_range_hi  <= range_hi_d;
         result_update  <= upd;
         result_channel <= conv_channel;
         pass_done      <= done;
      end
   end

   // ***********************************
   // assertions
   // ***********************************
   logic [31:0] slot_cnt_q;
   logic [31:0] pass_cnt_q;
   logic        pass_start_q;
   logic        restart_q;

   // cycles since the slot and the pass began
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         slot_cnt_q   <= '0;
         pass_cnt_q   <= '0;
         pass_start_q <= 1'b0;
         restart_q    <= 1'b0;
      end else begin
         slot_cnt_q   <= conv_start ? 32'h1 : slot_cnt_q + 32'h1;
         pass_cnt_q   <= pass_start_q ? 32'h1 : pass_cnt_q + 32'h1;
         pass_start_q <= first;
         restart_q    <= first && (state_q == ST_WAIT);
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_lp_forces_idle: assert property (low_power_mode |=> !conv_active)
      else $error("converter active in low power mode");
   a_update_enabled: assert property (result_update |-> en_pass_q[result_channel])
      else $error("result update for disabled channel");
   a_channel_ascend: assert property (result_update && conv_start |-> conv_channel > result_channel)
      else $error("channel order broken");
   a_slot_length: assert property (result_update |-> slot_cnt_q == BUDGET_CYC)
      else $error("slot length wrong");
   a_pass_length: assert property (pass_done |-> pass_cnt_q == BUDGET_CYC * $countones(en_pass_q))
      else $error("pass length wrong");
   a_repeat_period: assert property (pass_start_q && restart_q |-> pass_cnt_q == PERIOD_CYC)
      else $error("repeat period wrong");
   a_oneshot_clear: assert property (pass_done && !$past(repeat_q) && !$past(hi_wr) |-> !start_q)
      else $error("start bit not cleared after one-shot pass");
   a_stop_idle: assert property (hi_wr && !reg_wdata[`OPT_START_BIT-8] |-> ##2 !conv_active)
      else $error("converter running after stop");
   a_empty_start: assert property (state_q == ST_IDLE && start_q && !low_power_mode && en_q == 8'h00
                                   && !repeat_q && !hi_wr |=> !start_q && !result_update)
      else $error("empty start not completed");
   a_reset_value: assert property ($rose(rst_n) |-> opt_q == `OPT_RESET)
      else $error("option reset value wrong");
   // every channel but the two scaled inputs must stay on the fixed scale, adapter voltage included
   a_range_scope: assert property (conv_start && conv_channel != `CH_SYS_POWER
                                   && conv_channel != `CH_CMP_INPUT |-> !conv_range_hi)
      else $error("range applied to unscaled channel");

   c_oneshot_done: cover property (pass_done && !repeat_q);
   c_restart:      cover property (pass_start_q && restart_q);
   c_lp_abort:     cover property (conv_active ##1 !conv_active && low_power_mode);
   c_empty_start:  cover property (hw_clr && state_q == ST_IDLE);
endmodule

// ### dv/host_model.sv
// host-side model that drives the option register byte bus and the low power level
`timescale 1ns/1ps
module host_model (
   input  wire logic       ref_clk,
   input  wire logic [7:0] reg_rdata,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            low_power_mode
);
   // the device comes up in low power mode, as a battery-only system would
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      low_power_mode = 1'b1;
   end

   // one-cycle strobe; released lines show inverted leftovers so stale data never looks valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask

   // read data is registered, so it is taken one cycle after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask

   // low power level changes only between bus accesses
   task automatic lp(input logic v);
      @(negedge ref_clk);
      low_power_mode = v;
   endtask
endmodule

// ### dv/adc_conversion_control_test.sv
// self-checking bench for the converter option register and channel sequencer
`timescale 1ns/1ps
module adc_conversion_control_test import conv_ctrl_pkg::*;;
   localparam int BUDGET = 10;
   localparam int PERIOD = 100;
   localparam int LIMIT  = 3000;
   logic       ref_clk = 1'b0;
   logic       resetn = 1'b0;
   logic       low_power_mode;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic       conv_active;
   logic       conv_start;
   channel_t   conv_channel;
   logic       conv_range_hi;
   logic       result_update;
   channel_t   result_channel;
   logic       pass_done;
   int         num_errors = 0;
   int         checks_done = 0;
   int         cyc = 0;
   int         nres = 0;
   int         npass = 0;
   int         pass_cyc = 0;
   int         st_cyc[$];
   channel_t   st_ch[$];
   logic       st_rng[$];

   // short slot and period so a repeat run stays in a few hundred cycles
   host_model host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .low_power_mode(low_power_mode));
   adc_conversion_control #(.BUDGET_CYC(BUDGET), .PERIOD_CYC(PERIOD)) uut (.ref_clk(ref_clk),
      .resetn(resetn), .low_power_mode(low_power_mode), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_active(conv_active),
      .conv_start(conv_start), .conv_channel(conv_channel), .conv_range_hi(conv_range_hi),
      .result_update(result_update), .result_channel(result_channel), .pass_done(pass_done));

   // 40 MHz clock
   always #12.5 ref_clk = ~ref_clk;

   // ****************************
   // checking helpers
   // ****************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      host.rd(a, v);
      chk(v, exp);
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // slot log, sampled mid-cycle where the registered outputs have settled;
   // the result is matched against the slot before a new slot is pushed
   always @(negedge ref_clk) begin
      cyc++;
      if (result_update === 1'b1) begin
         nres++;
         chk(result_channel, st_ch[$]);
      end
      if (pass_done === 1'b1) begin
         npass++;
         pass_cyc = cyc;
      end
      if (conv_start === 1'b1) begin
         st_cyc.push_back(cyc);
         st_ch.push_back(conv_channel);
         st_rng.push_back(conv_range_hi);
      end
      // a hang counts as a mismatch and closes the run
      if (cyc == LIMIT) begin
         num_errors++;
         test_done();
      end
   end

   task automatic clr();
      st_cyc.delete();
      st_ch.delete();
      st_rng.delete();
      nres = 0;
      npass = 0;
   endtask

   // one start request: n slots expected, hx is the high byte read back afterwards
   task automatic run(input logic [7:0] en, input logic [7:0] hi, input int n, input logic [7:0] hx);
      int k;
      k = 0;
      clr();
      host.wr(8'h3a, en);
      host.wr(8'h3b, hi);
      repeat (n * BUDGET + 20) @(negedge ref_clk);
      chk(st_ch.size(), n);
      chk(nres, n);
      if (n > 0) begin
         chk(npass, 1);
         chk(pass_cyc - st_cyc[0], n * BUDGET);
      end
      if (st_ch.size() == n && n > 0) begin
         for (int i = 0; i < 8; i++) begin
            if (en[i]) begin
               chk(st_ch[k], i);
               chk(st_rng[k], hi[5] && (i == 5 || i == 7));
               chk(st_cyc[k] - st_cyc[0], k * BUDGET);
               k++;
            end
         end
      end
      rchk(8'h3b, hx);
   endtask

   // ****************************
   // test sequence
   // ****************************
   initial begin
      repeat (8) @(negedge ref_clk);
      resetn = 1'b1;
      repeat (3) @(negedge ref_clk);
      rchk(8'h3a, 8'h00);
      rchk(8'h3b, 8'h20);
      rchk(8'h3c, 8'h00);
      host.wr(8'h3b, 8'h1f);
      rchk(8'h3b, 8'h1f);
      // the host leaves low power mode before it enables any channel
      host.lp(1'b0);
      host.wr(8'h3a, 8'hff);
      rchk(8'h3a, 8'hff);
      run(8'ha5, 8'h60, 4, 8'h20);
      run(8'h20, 8'h40, 1, 8'h00);
      run(8'h00, 8'h60, 0, 8'h20);
      host.lp(1'b1);
      run(8'h01, 8'h60, 0, 8'h60);
      clr();
      host.lp(1'b0);
      repeat (BUDGET + 20) @(negedge ref_clk);
      chk(nres, 1);
      rchk(8'h3b, 8'h20);
      // continuous mode: three passes one period apart, then stopped by clearing start
      clr();
      host.wr(8'h3b, 8'he0);
      repeat (2 * PERIOD + BUDGET + 10) @(negedge ref_clk);
      chk(npass, 3);
      chk(st_cyc[1] - st_cyc[0], PERIOD);
      chk(st_cyc[2] - st_cyc[1], PERIOD);
      host.wr(8'h3b, 8'h00);
      repeat (PERIOD + 20) @(negedge ref_clk);
      chk(st_cyc.size(), 3);
      chk(conv_active, 1'b0);
      test_done();
   end
endmodule
